/* File: design/cftc_fetch_ctrl.sv */
module cftc_fetch_ctrl (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic compat_fuse,
   input wire logic code_ext,
   input wire logic [7:0] code_data,
   input wire logic [1:0] ins_len,
   input wire logic [2:0] ins_extra,
   input wire logic [2:0] ins_mcycles,
   input wire logic redirect_valid,
   input wire logic [15:0] redirect_addr,
   output logic fetch_req,
   output logic [15:0] fetch_addr,
   output logic [7:0] ins_byte,
   output logic ins_byte_valid,
   output logic ins_start,
   output logic ins_done,
   output logic fast_mode,
   output logic mode_valid,
   output logic [2:0] mstate
);
   // ****************************************
   // state and pacing
   // ****************************************
   cftc_pkg::cftc_state_s s_ff;
   cftc_pkg::cftc_state_s nxt_s;
   cftc_fetch_if fif ();
   logic byte_st;
   logic take;

   cftc_pacer u_pacer (
      .mclk(mclk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .fif(fif)
   );

   assign byte_st = (s_ff.st == cftc_pkg::ST_BYTES) ||
                    ((s_ff.st == cftc_pkg::ST_FIRST) && (s_ff.fast || s_ff.phase == 4'h0));
   assign fif.go = byte_st || (s_ff.st == cftc_pkg::ST_EXTRA);
   assign fif.fast = s_ff.fast;
   // compatibility timing never looks at where the code lives
   assign fif.ext = s_ff.fast && code_ext; // RL11
   // pacer parked on its slot until the mode is known, so phase 0 of the first cycle fetches
   assign fif.sync = !s_ff.fast && (!s_ff.mode_ok || (s_ff.phase == cftc_pkg::MC_LAST));
   assign take = fif.strobe && byte_st;
   assign fetch_req = take && clk_en;

   assign fetch_addr = s_ff.pc;
   assign ins_byte = s_ff.byte_q;
   assign ins_byte_valid = s_ff.byte_vld;
   assign ins_start = s_ff.start;
   assign ins_done = s_ff.done;
   assign fast_mode = s_ff.fast;
   assign mode_valid = s_ff.mode_ok;
   assign mstate = s_ff.fast ? 3'h0 : 3'(s_ff.phase / cftc_pkg::STATE_CLKS);

   // ****************************************
   // first-byte decode
   // ****************************************
   // a zero from the decoder means the shortest form
   function automatic logic [1:0] dec_len(input logic [1:0] raw);
      dec_len = (raw == 2'h0) ? cftc_pkg::LEN_ONE : raw;
   endfunction : dec_len

   // machine cycles still to run once the first one is under way
   function automatic logic [2:0] dec_mc_left(input logic [2:0] raw);
      dec_mc_left = (raw == 3'h0) ? 3'h0 : raw - 3'h1;
   endfunction : dec_mc_left

   // ****************************************
   // sequencing
   // ****************************************
   always_comb begin
      logic [1:0] got_n;
      got_n = s_ff.got + 2'h1;
      nxt_s = s_ff;
      nxt_s.sync = {s_ff.sync[1:0], compat_fuse};
      nxt_s.byte_vld = 1'b0;
      nxt_s.start = 1'b0;
      nxt_s.done = 1'b0;
      if (!s_ff.fast && s_ff.mode_ok) begin
         // twelve clocks per machine cycle, two per state
         nxt_s.phase = (s_ff.phase == cftc_pkg::MC_LAST) ? 4'h0 : s_ff.phase + 4'h1; // RL9
      end
      case (s_ff.st)
         cftc_pkg::ST_WAIT: begin
            if (s_ff.wait_cnt != cftc_pkg::SYNC_STAGES) begin
               nxt_s.wait_cnt = s_ff.wait_cnt + 2'h1;
            end else if (s_ff.sync[2] == s_ff.sync[1]) begin
               // strap caught once; nothing later changes it
               nxt_s.fast = !s_ff.sync[2]; // RL1 RL7 RL12
               nxt_s.mode_ok = 1'b1;
               nxt_s.phase = 4'h0;
               nxt_s.st = cftc_pkg::ST_FIRST;
            end
         end
         cftc_pkg::ST_FIRST, cftc_pkg::ST_BYTES: begin
            if (take) begin
               nxt_s.byte_q = code_data;
               nxt_s.byte_vld = 1'b1;
               nxt_s.pc = s_ff.pc + 16'h0001; // RL2
               if (s_ff.st == cftc_pkg::ST_FIRST) begin
                  nxt_s.start = 1'b1;
                  nxt_s.len = dec_len(ins_len);
                  nxt_s.extra = ins_extra;
                  nxt_s.mc_left = dec_mc_left(ins_mcycles); // RL10
                  nxt_s.got = cftc_pkg::LEN_ONE;
                  got_n = cftc_pkg::LEN_ONE;
               end else begin
                  nxt_s.got = got_n;
               end
               if (got_n == nxt_s.len) begin
                  if (!s_ff.fast) begin
                     nxt_s.st = cftc_pkg::ST_HOLD; // RL10
                  end else if (nxt_s.extra != 3'h0) begin
                     nxt_s.st = cftc_pkg::ST_EXTRA; // RL5
                  end else begin
                     // done beside the last byte; with internal code the next fetch starts at once
                     nxt_s.done = 1'b1; // RL3 RL4
                     nxt_s.st = cftc_pkg::ST_FIRST;
                     if (redirect_valid) begin
                        nxt_s.pc = redirect_addr;
                     end
                  end
               end else begin
                  nxt_s.st = cftc_pkg::ST_BYTES;
               end
            end
         end
         cftc_pkg::ST_EXTRA: begin
            // extra slots are paced too, so external code stays three times slower
            if (fif.strobe) begin
               nxt_s.extra = s_ff.extra - 3'h1; // RL5 RL6
               if (s_ff.extra == 3'h1) begin
                  nxt_s.done = 1'b1;
                  nxt_s.st = cftc_pkg::ST_FIRST;
                  if (redirect_valid) begin
                     nxt_s.pc = redirect_addr;
                  end
               end
            end
         end
         cftc_pkg::ST_HOLD: begin
            if (s_ff.phase == cftc_pkg::MC_LAST) begin
               if (s_ff.mc_left == 3'h0) begin
                  nxt_s.done = 1'b1; // RL10
                  nxt_s.st = cftc_pkg::ST_FIRST;
                  if (redirect_valid) begin
                     nxt_s.pc = redirect_addr;
                  end
               end else begin
                  nxt_s.mc_left = s_ff.mc_left - 3'h1;
               end
            end
         end
         default: begin
            nxt_s.st = cftc_pkg::ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '{sync: 3'h0, wait_cnt: 2'h0, mode_ok: 1'b0, fast: 1'b0,
                   st: cftc_pkg::ST_WAIT, pc: cftc_pkg::RESET_PC, byte_q: 8'h00,
                   byte_vld: 1'b0, start: 1'b0, done: 1'b0, len: 2'h0, got: 2'h0,
                   extra: 3'h0, mc_left: 3'h0, phase: 4'h0};
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n || !clk_en);

   mode_fuse_a: assert property ($rose(s_ff.mode_ok) |-> s_ff.fast == !$past(s_ff.sync[2])) // RL1
      else $error("mode does not follow fuse");
   mode_hold_a: assert property (s_ff.mode_ok && $past(s_ff.mode_ok) |-> $stable(s_ff.fast)) // RL12
      else $error("mode changed after capture");
   fast_fetch_a: assert property (s_ff.fast && s_ff.st == cftc_pkg::ST_BYTES && !code_ext // RL2
      |-> fetch_req)
      else $error("fast internal byte not fetched");
   pipe_overlap_a: assert property (ins_done && s_ff.fast && !code_ext |-> fetch_req) // RL3
      else $error("no fetch beside completion");
   one_byte_a: assert property (fetch_req && s_ff.fast && s_ff.st == cftc_pkg::ST_FIRST && // RL4
      !code_ext && ins_len == 2'h1 && ins_extra == 3'h0 |=> ins_done && ins_start)
      else $error("one-byte instruction not one clock");
   extra_cycle_a: assert property (s_ff.fast && s_ff.st == cftc_pkg::ST_EXTRA && // RL5
      s_ff.extra == 3'h1 && !code_ext |=> ins_done)
      else $error("extra cycle not ending");
   ext_slow_a: assert property (fetch_req && s_ff.fast && code_ext |=> !fetch_req [*2]) // RL6
      else $error("external fetch too fast");
   compat_gap_a: assert property (fetch_req && !s_ff.fast |=> !fetch_req [*2]) // RL8
      else $error("compat fetch spacing wrong");
   compat_end_a: assert property (ins_done && !s_ff.fast |-> s_ff.phase == 4'h0) // RL9
      else $error("compat instruction not on machine cycle");
   compat_slot_a: assert property (!s_ff.fast && s_ff.st == cftc_pkg::ST_BYTES // RL11
      |-> fetch_req == (s_ff.phase % 4'h3 == 4'h0))
      else $error("compat slot moved");
   // byte path, machine-cycle placement and compat code location
   byte_valid_a: assert property (fetch_req |=> ins_byte_valid) // RL2
      else $error("taken byte not passed on");
   byte_value_a: assert property (fetch_req |=> ins_byte == $past(code_data)) // RL2
      else $error("passed byte differs from code");
   start_byte_a: assert property (ins_start |-> ins_byte_valid) // RL3
      else $error("start without its byte");
   mstate_range_a: assert property (mode_valid && !fast_mode |-> mstate <= 3'h5) // RL9
      else $error("machine state out of range");
   compat_start_a: assert property (ins_start && !s_ff.fast |-> s_ff.phase == 4'h1) // RL9
      else $error("compat start off machine cycle");
   compat_ext_a: assert property (!s_ff.fast |-> !fif.ext) // RL11
      else $error("compat pacing sees code location");

   ext_fetch_c: cover property (fetch_req && s_ff.fast && code_ext);
   branch_c: cover property (ins_done && s_ff.fast && $past(s_ff.st) == cftc_pkg::ST_EXTRA);
   compat_long_c: cover property (ins_done && !s_ff.fast && $past(s_ff.mc_left) == 3'h0 &&
      $past(s_ff.st, 13) == cftc_pkg::ST_HOLD);
   compat_ext_c: cover property (ins_done && !s_ff.fast && code_ext);
endmodule : cftc_fetch_ctrl

/* File: design/cftc_fetch_if.sv */
interface cftc_fetch_if;
   logic go;
   logic fast;
   logic ext;
   logic sync;
   logic strobe;
   modport ctrl (output go, output fast, output ext, output sync, input strobe);
   modport pacer (input go, input fast, input ext, input sync, output strobe);
endinterface : cftc_fetch_if

/* File: design/cftc_pacer.sv */
module cftc_pacer (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   cftc_fetch_if.pacer fif
);
   typedef struct packed {
      logic [1:0] cnt;
   } cftc_pacer_s;

   cftc_pacer_s s_ff;
   cftc_pacer_s nxt_s;
   logic last;

   assign last = (s_ff.cnt == cftc_pkg::FETCH_DIV - 2'h1);
   // internal fast code takes a slot every clock, otherwise every third
   assign fif.strobe = fif.go && ((fif.fast && !fif.ext) || last); // RL2 RL6 RL8

   always_comb begin
      nxt_s = s_ff;
      if (fif.sync) begin
         // line the slots up with the machine-cycle start
         nxt_s.cnt = cftc_pkg::FETCH_DIV - 2'h1; // RL8 RL11
      end else if (fif.fast && !fif.go) begin
         nxt_s.cnt = 2'h0;
      end else if (last) begin
         nxt_s.cnt = 2'h0;
      end else begin
         nxt_s.cnt = s_ff.cnt + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else if (clk_en) begin
         s_ff <= nxt_s;
      end
   end
endmodule : cftc_pacer

/* File: design/cftc_pkg.sv */
// Overview of operation
// RL1 - fast single-cycle mode runs only when the compatibility fuse is cleared
// RL2 - fast mode fetches one code byte every system clock
// RL3 - two-stage pipeline overlaps next fetch with current execute
// RL4 - fast mode: 1 to 3 byte instructions take one clock per byte
// RL5 - fast mode: branches and calls add a cycle; complex ones add several
// RL6 - fast mode: external code memory makes instructions three times slower
// RL7 - compatibility mode runs when the fuse is set, the factory default
// RL8 - compatibility mode fetches one byte every three system clocks
// RL9 - compatibility mode: six states of two clocks, twelve clocks per machine cycle
// RL10 - compatibility mode: instructions take one, two or four machine cycles
// RL11 - compatibility mode timing is the same for internal and external code
// RL12 - mode is sampled from the fuse at reset and held until next reset
package cftc_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam logic [15:0] RESET_PC = 16'h0000;
   localparam logic [1:0] SYNC_STAGES = 2'h3;
   localparam logic [1:0] FETCH_DIV = 2'h3;
   localparam logic [3:0] STATE_CLKS = 4'h2;
   localparam logic [3:0] MC_STATES = 4'h6;
   localparam logic [3:0] MC_CLKS = 4'hc;
   localparam logic [3:0] MC_LAST = MC_CLKS - 4'h1;
   localparam logic [1:0] LEN_ONE = 2'h1;

   typedef enum logic [2:0] {
      ST_WAIT,
      ST_FIRST,
      ST_BYTES,
      ST_EXTRA,
      ST_HOLD
   } cftc_st_e;

   typedef struct packed {
      logic [2:0] sync;
      logic [1:0] wait_cnt;
      logic mode_ok;
      logic fast;
      cftc_st_e st;
      logic [15:0] pc;
      logic [7:0] byte_q;
      logic byte_vld;
      logic start;
      logic done;
      logic [1:0] len;
      logic [1:0] got;
      logic [2:0] extra;
      logic [2:0] mc_left;
      logic [3:0] phase;
   } cftc_state_s;
endpackage : cftc_pkg

/* File: verification/cftc_code_mem.sv */
module cftc_code_mem (
   input wire logic mclk,
   input wire logic fetch_req,
   input wire logic [15:0] fetch_addr,
   output logic code_ext,
   output logic [7:0] code_data,
   output logic [1:0] ins_len,
   output logic [2:0] ins_extra,
   output logic [2:0] ins_mcycles
);
   timeunit 1ns;
   timeprecision 1ps;
   // code: [1:0] length, [4:2] extra cycles, [7:5] machine cycles
   logic [7:0] mem [256];
   logic [7:0] junk;
   initial begin
      junk = 8'h5a;
      foreach (mem[i]) mem[i] = 8'h21;
      mem[0] = 8'h22;
      mem[2] = 8'h41;
      mem[3] = 8'h83;
      mem[6] = 8'h29;
      mem[64] = 8'h46;
   end
   // bus not read shows a moving pattern, never the last byte
   always @(posedge mclk) junk <= junk + 8'h35;
   // top half of the space is external; same cells, so timings compare directly
   assign code_ext = fetch_addr[15];
   assign code_data = fetch_req ? mem[fetch_addr[7:0]] : junk;
   assign ins_len = code_data[1:0];
   assign ins_extra = code_data[4:2];
   assign ins_mcycles = code_data[7:5];
endmodule : cftc_code_mem

/* File: verification/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_en = 1'b1;
   logic compat_fuse = 1'b0;
   logic redirect_valid = 1'b0;
   logic [15:0] redirect_addr = 16'h0000;
   logic code_ext, fetch_req, ins_byte_valid, ins_start, ins_done, fast_mode, mode_valid;
   logic [7:0] code_data, ins_byte;
   logic [1:0] ins_len;
   logic [2:0] ins_extra, ins_mcycles, mstate;
   logic [15:0] fetch_addr;
   int fails = 0, checked = 0, cyc = 0;
   int st_q[$], fr_q[$], dn_q[$], bv_q[$];
   logic [7:0] sb_q[$];

   always #4 mclk = ~mclk;

   cftc_code_mem cftc_code_mem_i (.mclk(mclk), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .code_ext(code_ext), .code_data(code_data),
      .ins_len(ins_len), .ins_extra(ins_extra), .ins_mcycles(ins_mcycles));

   cftc_fetch_ctrl cftc_fetch_ctrl_i (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
      .compat_fuse(compat_fuse), .code_ext(code_ext), .code_data(code_data),
      .ins_len(ins_len), .ins_extra(ins_extra), .ins_mcycles(ins_mcycles),
      .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .ins_byte(ins_byte),
      .ins_byte_valid(ins_byte_valid), .ins_start(ins_start), .ins_done(ins_done),
      .fast_mode(fast_mode), .mode_valid(mode_valid), .mstate(mstate));

   // ***************************
   // cycle stamps of fetches, completions, byte valids and starts
   // ***************************
   always @(posedge mclk) begin
      cyc++;
      if (fetch_req === 1'b1) fr_q.push_back(cyc);
      if (ins_done === 1'b1) dn_q.push_back(cyc);
      if (ins_byte_valid === 1'b1) bv_q.push_back(cyc);
      if (ins_start === 1'b1) begin
         st_q.push_back(cyc);
         sb_q.push_back(ins_byte);
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic clr();
      st_q.delete();
      fr_q.delete();
      sb_q.delete();
      dn_q.delete();
      bv_q.delete();
   endtask : clr

   task automatic wait_st(input int n);
      int k;
      k = 0;
      while (st_q.size() < n && k < 3000) begin
         @(posedge mclk);
         k++;
      end
      #1;
      if (k >= 3000) begin
         fails++;
         $display("CHECK FAILED t=%0t no instruction start", $time);
         close_out();
      end
   endtask : wait_st

   task automatic do_reset(input logic fuse);
      int n;
      @(posedge mclk);
      reset_n <= 1'b0;
      compat_fuse <= fuse;
      redirect_valid <= 1'b0;
      repeat (5) @(posedge mclk);
      chk(fetch_addr, 32'h0, "reset address");
      clr();
      reset_n <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (mode_valid !== 1'b1 && n < 20);
      chk(n, 32'h4, "mode capture edge");
      chk(fast_mode, !fuse, "mode from fuse");
   endtask : do_reset

   // settle on a self-looping instruction, then time two turns
   task automatic loop_at(input logic [15:0] a, input int exp);
      @(posedge mclk);
      redirect_addr <= a;
      redirect_valid <= 1'b1;
      #1;
      clr();
      wait_st(2);
      clr();
      wait_st(3);
      chk(st_q[1] - st_q[0], exp, "loop period");
      chk(st_q[2] - st_q[1], exp, "loop period");
      chk(sb_q[2], 8'h46, "loop byte");
   endtask : loop_at

   task automatic fast_seq();
      do_reset(1'b0);
      wait_st(5);
      chk(st_q[0] - fr_q[0], 1, "first start");
      chk(fr_q[6] - fr_q[0], 6, "fetch rate");
      chk(st_q[1] - st_q[0], 2, "two byte");
      chk(st_q[2] - st_q[1], 1, "one byte");
      chk(st_q[3] - st_q[2], 3, "three byte");
      chk(st_q[4] - st_q[3], 3, "extra cycles");
      chk(sb_q[2], 8'h83, "start byte");
      chk(bv_q[6] - fr_q[6], 1, "byte valid lag");
      chk(dn_q[0] - st_q[0], 1, "two byte done");
      chk(dn_q[0], fr_q[2], "fetch beside done");
      chk(dn_q[3] - st_q[3], 2, "extra done");
      loop_at(16'h0040, 3);
      loop_at(16'h8040, 9);
   endtask : fast_seq

   // fuse flips while frozen; the captured mode must survive
   task automatic freeze_hold();
      @(posedge mclk);
      compat_fuse <= 1'b1;
      clk_en <= 1'b0;
      #1;
      clr();
      repeat (6) @(posedge mclk);
      #1;
      chk(fr_q.size(), 0, "frozen fetch");
      @(posedge mclk);
      clk_en <= 1'b1;
      repeat (30) @(posedge mclk);
      #1;
      chk(fast_mode, 1'b1, "mode held");
   endtask : freeze_hold

   // machine state index steps every two clocks from a completion
   task automatic mstate_walk();
      int n;
      n = 0;
      while (ins_done !== 1'b1 && n < 60) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(ins_done, 1'b1, "completion seen");
      for (int k = 0; k < 12; k++) begin
         chk(mstate, k / 2, "machine state");
         @(posedge mclk);
         #1;
      end
   endtask : mstate_walk

   task automatic compat_seq();
      do_reset(1'b1);
      wait_st(5);
      chk(dn_q[0], fr_q[2], "fetch beside done");
      chk(dn_q[2] - st_q[2], 47, "four mcycle done");
      chk(st_q[1] - st_q[0], 12, "one mcycle");
      chk(st_q[2] - st_q[1], 24, "two mcycles");
      chk(st_q[3] - st_q[2], 48, "four mcycles");
      chk(fr_q[4] - fr_q[3], 3, "byte spacing");
      chk(fr_q[5] - fr_q[4], 3, "byte spacing");
      mstate_walk();
      loop_at(16'h0040, 24);
      loop_at(16'h8040, 24);
   endtask : compat_seq

   task automatic close_out();
      $display("checks %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out

   initial begin
      fast_seq();
      freeze_hold();
      compat_seq();
      close_out();
   end

   initial begin
      // about ten times the expected run
      repeat (5000) @(posedge mclk);
      fails++;
      close_out();
   end
endmodule : tb
